/* File: verilog/dcm_params.svh */
// Purpose: Named offsets, field positions and reset values of the digitizer control-bus map.
// Assumes: Byte addresses are the low eight control-bus address lines.
// Notes: Native offsets start with DCM_N_, original-layout offsets with DCM_O_.
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
`define DCM_PIN_W 27
`define DCM_BCAST_SEL 5'h13
`define DCM_IND_TOP 1'h0
`define DCM_MAP_BIT 7
`define DCM_ALT_BIT 4
`define DCM_FREEZE_BIT 7
`define DCM_ALT_SHIFT 7'h20
`define DCM_IMM_LEN_LO 8'h01
`define DCM_IMM_LEN_HI 8'h00
`define DCM_INIT_LAST 4'hf
`define DCM_N_THR_IMM 8'h00
`define DCM_N_THR_FAST 8'h10
`define DCM_N_THR_SLOW 8'h20
`define DCM_N_THR_VSLOW 8'h30
`define DCM_N_SET 8'h40
`define DCM_N_LEN_IMM 8'h40
`define DCM_N_LEN_FAST 8'h42
`define DCM_N_CONST 8'h48
`define DCM_N_SQL 8'h50
`define DCM_N_PEDLO 8'h58
`define DCM_N_PEDHI 8'h60
`define DCM_N_MODE 8'h68
`define DCM_N_DAC 8'h70
`define DCM_N_TDAC 8'h78
`define DCM_N_SLOPE 8'h7a
`define DCM_N_CIC 8'h7c
`define DCM_N_PEDLEN 8'h7e
`define DCM_N_DRIP 8'h80
`define DCM_N_FAST 8'h90
`define DCM_N_SLOW 8'ha0
`define DCM_N_VSLOW 8'hb0
`define DCM_N_INTEG 8'hc0
`define DCM_N_SUM_END 8'hdf
`define DCM_N_THR_UP 8'he0
`define DCM_N_THR_BP 8'he1
`define DCM_N_SET_UP 8'he2
`define DCM_N_SET_BP 8'he3
`define DCM_N_SUM_WP 8'he4
`define DCM_N_SUM_FP 8'he5
`define DCM_N_SUM_SP 8'he6
`define DCM_N_SUM_VP 8'he7
`define DCM_N_RING 8'hf6
`define DCM_N_RING_HI 8'hf7
`define DCM_N_CTRL 8'hf8
`define DCM_N_CTRL_HI 8'hf9
`define DCM_N_TEMP 8'hfc
`define DCM_N_TEMP_HI 8'hfd
`define DCM_N_MAP 8'hff
`define DCM_O_CH1 8'h30
`define DCM_O_CH2 8'h60
`define DCM_O_CH3 8'h90
`define DCM_O_END 8'hc0
`define DCM_O_SUMS 8'h10
`define DCM_O_MODE 8'h1c
`define DCM_O_DAC 8'h1e
`define DCM_O_DRIP 8'h20
`define DCM_O_PEDHI 8'h22
`define DCM_O_CONST 8'h24
`define DCM_O_PEDLO 8'h26
`define DCM_O_INTEG 8'h28
`define DCM_O_DRIP32 8'hc0
`define DCM_O_SQL 8'hd0
`define DCM_O_SQL_END 8'hd7
`define DCM_O_SLOPE 8'hda
`define DCM_O_CIC 8'hdc
`define DCM_O_PEDLEN 8'hea
`define DCM_O_LEN_IMM 8'hec
`define DCM_O_LEN_FAST 8'hf0
`define DCM_O_LEN_END 8'hf5
`define DCM_O_TDAC 8'hfa
`endif

/* File: verilog/dcm_pkg.sv */
// Purpose: Types shared by the digitizer control-bus map.
// Assumes: Offsets and values live in dcm_params.svh.
// Notes: Holds types only.
package dcm_pkg;
    typedef enum logic [0:0] {
        DCM_INIT = 1'b0,
        DCM_RUN = 1'b1
    } dcm_state_t;
    typedef logic [7:0] dcm_byte_t;
endpackage : dcm_pkg

/* File: verilog/dcm_bus_map.sv */
// Purpose: Control-bus register file of a four-channel digitizer card.
// Assumes: Bus pins are asynchronous; latch and sum-write inputs share clk.
// Notes: Storage is native order; the original layout is a translation in front.
`timescale 1ns/1ps
`include "dcm_params.svh"
module dcm_bus_map (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [12:0] cb_addr,
    input wire logic [7:0] cb_data_in,
    input wire logic cb_wr,
    input wire logic cb_rd,
    input wire logic [3:0] card_sw,
    output logic [7:0] cb_data_out,
    output logic cb_data_oe,
    input wire logic [2:0] sum_latch,
    input wire logic sum_wr_en,
    input wire logic [6:0] sum_wr_index,
    input wire logic [7:0] sum_wr_data,
    input wire logic [15:0] ring_buffer_pointer,
    input wire logic [15:0] temperature_reading,
    input wire logic [5:0] thr_use_index,
    output logic [7:0] thr_use_data,
    input wire logic [5:0] set_use_index,
    output logic [7:0] set_use_data,
    output logic [7:0] mapping_control,
    output logic [15:0] card_control_word,
    output logic [2:0] sum_write_page,
    output logic init_done
);
    logic [`DCM_PIN_W-1:0] pin_s1_ff;
    logic [`DCM_PIN_W-1:0] pin_s2_ff;
    logic [12:0] addr_s;
    logic [7:0] wdata_s;
    logic wr_s;
    logic rd_s;
    logic [3:0] sw_s;
    logic wr_d_ff;
    logic wr_pulse;
    logic sel_card;
    logic [8:0] xl;
    logic [7:0] eff;
    logic eff_ok;
    logic wr_go;
    logic rd_go;
    dcm_pkg::dcm_state_t state_ff;
    logic [3:0] init_cnt_ff;
    logic [7:0] mem_thr [0:4095];
    logic [7:0] mem_set [0:511];
    logic [7:0] mem_sum [0:1023];
    logic [7:0] thr_up_ff;
    logic [7:0] thr_bp_ff;
    logic [7:0] set_up_ff;
    logic [7:0] set_bp_ff;
    logic [7:0] sum_wp_ff;
    logic [7:0] sum_rp_ff [0:2];
    logic [7:0] map_ff;
    logic [15:0] ctrl_ff;
    logic [7:0] rdata_ff;
    logic oe_ff;
    logic [7:0] thr_use_ff;
    logic [7:0] set_use_ff;
    logic [7:0] rd_byte;
    logic [2:0] rd_page;
    logic [6:0] rd_idx;

    // Translates an original-layout byte address into its native location.
    function automatic logic [8:0] dcm_xlate(input logic [7:0] o);
        logic [1:0] ch;
        logic [7:0] base;
        logic [7:0] rel;
        logic [7:0] c2;
        logic [7:0] c4;
        logic [7:0] nat;
        logic ok;
        ch = 2'h3;
        if (o < `DCM_O_CH1) begin
            ch = 2'h0;
        end else if (o < `DCM_O_CH2) begin
            ch = 2'h1;
        end else if (o < `DCM_O_CH3) begin
            ch = 2'h2;
        end
        case (ch)
            2'h0: base = 8'h00;
            2'h1: base = `DCM_O_CH1;
            2'h2: base = `DCM_O_CH2;
            default: base = `DCM_O_CH3;
        endcase
        rel = o - base;
        c2 = {5'h00, ch, 1'b0};
        c4 = {4'h0, ch, 2'b00};
        nat = 8'h00;
        ok = 1'b1;
        if (o < `DCM_O_END) begin
            if (rel < `DCM_O_SUMS) begin
                case (rel[3:2])
                    2'h0: nat = `DCM_N_THR_FAST;
                    2'h1: nat = `DCM_N_THR_SLOW;
                    2'h2: nat = `DCM_N_THR_VSLOW;
                    default: nat = `DCM_N_THR_IMM;
                endcase
                nat = nat + c4 + {6'h00, rel[1:0]};
            end else if (rel < `DCM_O_MODE) begin
                case (rel[3:2])
                    2'h0: nat = `DCM_N_FAST;
                    2'h1: nat = `DCM_N_SLOW;
                    default: nat = `DCM_N_VSLOW;
                endcase
                nat = nat + c4 + {6'h00, rel[1:0]};
            end else if (rel < `DCM_O_DAC) begin
                nat = `DCM_N_MODE + c2 + {7'h00, rel[0]};
            end else if (rel < `DCM_O_DRIP) begin
                nat = `DCM_N_DAC + c2 + {7'h00, rel[0]};
            end else if (rel < `DCM_O_PEDHI) begin
                nat = `DCM_N_DRIP + c4 + {7'h00, rel[0]};
            end else if (rel < `DCM_O_CONST) begin
                nat = `DCM_N_PEDHI + c2 + {7'h00, rel[0]};
            end else if (rel < `DCM_O_PEDLO) begin
                nat = `DCM_N_CONST + c2 + {7'h00, rel[0]};
            end else if (rel < `DCM_O_INTEG) begin
                nat = `DCM_N_PEDLO + c2 + {7'h00, rel[0]};
            end else begin
                nat = `DCM_N_INTEG + {c4[6:0], 1'b0} + {5'h00, rel[2:0]};
            end
        end else if (o < `DCM_O_SQL) begin
            nat = `DCM_N_DRIP + (o - `DCM_O_DRIP32);
        end else if (o <= `DCM_O_SQL_END) begin
            nat = `DCM_N_SQL + (o - `DCM_O_SQL);
        end else if (o[7:1] == `DCM_O_SLOPE >> 1) begin
            nat = `DCM_N_SLOPE + {7'h00, o[0]};
        end else if (o[7:1] == `DCM_O_CIC >> 1) begin
            nat = `DCM_N_CIC + {7'h00, o[0]};
        end else if (o >= `DCM_N_THR_UP && o <= `DCM_N_SUM_VP) begin
            nat = o;
        end else if (o[7:1] == `DCM_O_PEDLEN >> 1) begin
            nat = `DCM_N_PEDLEN + {7'h00, o[0]};
        end else if (o[7:1] == `DCM_O_LEN_IMM >> 1) begin
            nat = `DCM_N_LEN_IMM + {7'h00, o[0]};
        end else if (o >= `DCM_O_LEN_FAST && o <= `DCM_O_LEN_END) begin
            nat = `DCM_N_LEN_FAST + (o - `DCM_O_LEN_FAST);
        end else if (o[7:1] == `DCM_O_TDAC >> 1) begin
            nat = `DCM_N_TDAC + {7'h00, o[0]};
        end else if (o >= `DCM_N_RING && o <= `DCM_N_CTRL_HI) begin
            nat = o;
        end else if (o == `DCM_N_TEMP || o == `DCM_N_TEMP_HI || o == `DCM_N_MAP) begin
            nat = o;
        end else begin
            ok = 1'b0;
        end
        dcm_xlate = {ok, nat};
    endfunction : dcm_xlate

    // Two-stage synchroniser for every bus pin.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            wr_d_ff <= 1'b0;
        end else begin
            pin_s1_ff <= {cb_addr, cb_data_in, cb_wr, cb_rd, card_sw};
            pin_s2_ff <= pin_s1_ff;
            wr_d_ff <= wr_s;
        end
    end

    assign {addr_s, wdata_s, wr_s, rd_s, sw_s} = pin_s2_ff;
    assign wr_pulse = wr_s & ~wr_d_ff;
    assign sel_card = (addr_s[12:8] == {`DCM_IND_TOP, sw_s}) || (addr_s[12:8] == `DCM_BCAST_SEL);
    assign xl = map_ff[`DCM_MAP_BIT] ? {1'b1, addr_s[7:0]} : dcm_xlate(addr_s[7:0]);
    assign eff = xl[7:0];
    assign eff_ok = xl[8];
    assign wr_go = wr_pulse & sel_card & eff_ok & (state_ff == dcm_pkg::DCM_RUN);
    assign rd_go = rd_s & sel_card;

    // Post-reset sequencer presets the immediate length word in each settings page.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= dcm_pkg::DCM_INIT;
            init_cnt_ff <= 4'h0;
        end else begin
            case (state_ff)
                dcm_pkg::DCM_INIT: begin
                    init_cnt_ff <= init_cnt_ff + 4'h1;
                    if (init_cnt_ff == `DCM_INIT_LAST) begin
                        state_ff <= dcm_pkg::DCM_RUN;
                    end
                end
                dcm_pkg::DCM_RUN: state_ff <= dcm_pkg::DCM_RUN;
                default: state_ff <= dcm_pkg::DCM_INIT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (wr_go && eff < `DCM_N_SET) begin
            mem_thr[{thr_bp_ff[5:0], eff[5:0]}] <= wdata_s;
        end
        thr_use_ff <= mem_thr[{thr_up_ff[5:0], thr_use_index}];
    end

    always_ff @(posedge clk) begin
        if (state_ff == dcm_pkg::DCM_INIT) begin
            mem_set[{init_cnt_ff[3:1], 5'h00, init_cnt_ff[0]}] <=
                init_cnt_ff[0] ? `DCM_IMM_LEN_HI : `DCM_IMM_LEN_LO;
        end else if (wr_go && eff >= `DCM_N_SET && eff < `DCM_N_DRIP) begin
            mem_set[{set_bp_ff[2:0], eff[5:0]}] <= wdata_s;
        end
        set_use_ff <= mem_set[{set_up_ff[2:0], set_use_index}];
    end

    // Sum pages are filled only by the processing logic at the current write page.
    always_ff @(posedge clk) begin
        if (sum_wr_en) begin
            mem_sum[{sum_wp_ff[2:0], sum_wr_index}] <= sum_wr_data;
        end
    end

    // Plain control registers; read-only locations are not decoded here.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            map_ff <= 8'h00;
            ctrl_ff <= 16'h0000;
            thr_up_ff <= 8'h00;
            thr_bp_ff <= 8'h00;
            set_up_ff <= 8'h00;
            set_bp_ff <= 8'h00;
        end else if (wr_go) begin
            case (eff)
                `DCM_N_MAP: map_ff <= wdata_s;
                `DCM_N_CTRL: ctrl_ff[7:0] <= wdata_s;
                `DCM_N_CTRL_HI: ctrl_ff[15:8] <= wdata_s;
                `DCM_N_THR_UP: thr_up_ff <= wdata_s;
                `DCM_N_THR_BP: thr_bp_ff <= wdata_s;
                `DCM_N_SET_UP: set_up_ff <= wdata_s;
                `DCM_N_SET_BP: set_bp_ff <= wdata_s;
                default: map_ff <= map_ff;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_wp_ff <= 8'h00;
        end else if (|sum_latch) begin
            sum_wp_ff <= {sum_wp_ff[7:3], sum_wp_ff[2:0] + 3'h1};
        end else if (wr_go && eff == `DCM_N_SUM_WP) begin
            sum_wp_ff <= wdata_s;
        end
    end

    // One read pointer per sum speed: fast, slow, very slow.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_rp
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    sum_rp_ff[gi] <= 8'h00;
                end else if (sum_latch[gi] && !sum_rp_ff[gi][`DCM_FREEZE_BIT]) begin
                    sum_rp_ff[gi] <= {sum_rp_ff[gi][7:3], sum_wp_ff[2:0]};
                end else if (wr_go && eff == `DCM_N_SUM_FP + 8'(gi)) begin
                    sum_rp_ff[gi] <= wdata_s;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_page = sum_rp_ff[2][2:0];
        if (eff < `DCM_N_SLOW) begin
            rd_page = sum_rp_ff[0][2:0];
        end else if (eff < `DCM_N_VSLOW) begin
            rd_page = sum_rp_ff[1][2:0];
        end
        rd_idx = 7'(eff - `DCM_N_DRIP);
        if (eff >= `DCM_N_INTEG && map_ff[`DCM_ALT_BIT]) begin
            rd_idx = rd_idx + `DCM_ALT_SHIFT;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (!eff_ok) begin
            rd_byte = 8'h00;
        end else if (eff < `DCM_N_SET) begin
            rd_byte = mem_thr[{thr_bp_ff[5:0], eff[5:0]}];
        end else if (eff < `DCM_N_DRIP) begin
            rd_byte = mem_set[{set_bp_ff[2:0], eff[5:0]}];
        end else if (eff <= `DCM_N_SUM_END) begin
            rd_byte = mem_sum[{rd_page, rd_idx}];
        end else begin
            case (eff)
                `DCM_N_THR_UP: rd_byte = thr_up_ff;
                `DCM_N_THR_BP: rd_byte = thr_bp_ff;
                `DCM_N_SET_UP: rd_byte = set_up_ff;
                `DCM_N_SET_BP: rd_byte = set_bp_ff;
                `DCM_N_SUM_WP: rd_byte = sum_wp_ff;
                `DCM_N_SUM_FP: rd_byte = sum_rp_ff[0];
                `DCM_N_SUM_SP: rd_byte = sum_rp_ff[1];
                `DCM_N_SUM_VP: rd_byte = sum_rp_ff[2];
                `DCM_N_RING: rd_byte = ring_buffer_pointer[7:0];
                `DCM_N_RING_HI: rd_byte = ring_buffer_pointer[15:8];
                `DCM_N_CTRL: rd_byte = ctrl_ff[7:0];
                `DCM_N_CTRL_HI: rd_byte = ctrl_ff[15:8];
                `DCM_N_TEMP: rd_byte = temperature_reading[7:0];
                `DCM_N_TEMP_HI: rd_byte = temperature_reading[15:8];
                `DCM_N_MAP: rd_byte = map_ff;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // Registered read answer; the data pins are driven while a selected read stands.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
            oe_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_byte;
            oe_ff <= rd_go;
        end
    end

    assign cb_data_out = rdata_ff;
    assign cb_data_oe = oe_ff;
    assign thr_use_data = thr_use_ff;
    assign set_use_data = set_use_ff;
    assign mapping_control = map_ff;
    assign card_control_word = ctrl_ff;
    assign sum_write_page = sum_wp_ff[2:0];
    assign init_done = state_ff;
endmodule : dcm_bus_map

/* File: test/dcm_ctl_model.sv */
// Purpose: Crate controller model that drives the digitizer control bus.
// Assumes: Strobes are active high levels sampled through two sync stages.
// Notes: Tasks are called from the testbench; released data shows the inverse.
`timescale 1ns/1ps
module dcm_ctl_model (
    input wire logic clk,
    output logic [12:0] cb_addr,
    output logic [7:0] cb_data_in,
    output logic cb_wr,
    output logic cb_rd,
    input wire logic [7:0] cb_data_out,
    input wire logic cb_data_oe
);
    // Bus idles with both strobes low.
    initial begin
        cb_addr = 13'h0000;
        cb_data_in = 8'h00;
        cb_wr = 1'b0;
        cb_rd = 1'b0;
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    // Addressed write with setup, hold and spacing.
    task automatic bus_write(input logic [12:0] a, input logic [7:0] d);
        tick();
        cb_addr = a;
        cb_data_in = d;
        repeat (3) tick();
        cb_wr = 1'b1;
        repeat (4) tick();
        cb_wr = 1'b0;
        tick();
        cb_data_in = ~d;
        repeat (3) tick();
    endtask : bus_write
    // Reads target one card only, never the shared range.
    task automatic bus_read(input logic [12:0] a, output logic [7:0] d);
        tick();
        cb_addr = a;
        cb_rd = 1'b1;
        for (int i = 0; i < 12 && cb_data_oe !== 1'b1; i++) begin
            tick();
        end
        repeat (2) tick();
        d = (cb_data_oe === 1'b1) ? cb_data_out : 8'hxx;
        cb_rd = 1'b0;
        repeat (4) tick();
    endtask : bus_read
endmodule : dcm_ctl_model

/* File: test/dcm_bus_map_properties.sv */
// Purpose: Port-level checks of the digitizer control-bus map.
// Assumes: One clock domain with asynchronous active-low reset.
// Notes: Bound to every instance of the map.
`timescale 1ns/1ps
module dcm_bus_map_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cb_wr,
    input wire logic cb_rd,
    input wire logic cb_data_oe,
    input wire logic [2:0] sum_latch,
    input wire logic [7:0] mapping_control,
    input wire logic [15:0] card_control_word,
    input wire logic [2:0] sum_write_page,
    input wire logic init_done
);
    // All checks share the one clock and its reset.
    default clocking dcm_ck @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    oe_on_read_a: assert property (cb_rd [*4] |-> cb_data_oe)
        else $error("data enable missing during a held read");
    oe_off_idle_a: assert property (!cb_rd [*4] |-> !cb_data_oe)
        else $error("data enable high without a read");
    oe_needs_read_a: assert property ($rose(cb_data_oe) |-> $past(cb_rd) && $past(cb_rd, 2))
        else $error("data enable rose too early");
    reset_clear_a: assert property ($rose(rst_b) |-> mapping_control == 8'h00 && sum_write_page == 3'h0
        && card_control_word == 16'h0000)
        else $error("registers not cleared by reset");
    init_window_a: assert property ($rose(rst_b) |-> ##[14:18] init_done)
        else $error("preset sequence did not finish in time");
    init_hold_a: assert property (init_done |=> init_done)
        else $error("preset done flag dropped");
    latch_step_a: assert property (sum_latch != 3'h0 |=> sum_write_page == $past(sum_write_page) + 3'h1)
        else $error("write page did not step on latch");
    quiet_stable_a: assert property ((sum_latch == 3'h0 && !cb_wr) [*3] |=> $stable(sum_write_page)
        && $stable(mapping_control) && $stable(card_control_word))
        else $error("register changed with no write or latch");
endmodule : dcm_bus_map_properties
bind dcm_bus_map dcm_bus_map_properties dcm_bus_map_properties_inst (
    .clk(clk),
    .rst_b(rst_b),
    .cb_wr(cb_wr),
    .cb_rd(cb_rd),
    .cb_data_oe(cb_data_oe),
    .sum_latch(sum_latch),
    .mapping_control(mapping_control),
    .card_control_word(card_control_word),
    .sum_write_page(sum_write_page),
    .init_done(init_done)
);

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the digitizer control-bus map.
// Assumes: Card switch is 5, so the card window is 0x05XX.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic rst_b;
    logic [12:0] cb_addr;
    logic [7:0] cb_data_in;
    logic cb_wr;
    logic cb_rd;
    logic [7:0] cb_data_out;
    logic cb_data_oe;
    logic [2:0] sum_latch;
    logic sum_wr_en;
    logic [6:0] sum_wr_index;
    logic [7:0] sum_wr_data;
    logic [5:0] thr_use_index;
    logic [7:0] thr_use_data;
    logic [5:0] set_use_index;
    logic [7:0] set_use_data;
    logic [7:0] mapping_control;
    logic [15:0] card_control_word;
    logic [2:0] sum_write_page;
    logic init_done;
    int fails = 0;
    int num_checks = 0;
    dcm_bus_map dcm_bus_map_inst (.clk(clk), .rst_b(rst_b), .cb_addr(cb_addr), .cb_data_in(cb_data_in),
        .cb_wr(cb_wr), .cb_rd(cb_rd), .card_sw(4'h5), .cb_data_out(cb_data_out), .cb_data_oe(cb_data_oe),
        .sum_latch(sum_latch), .sum_wr_en(sum_wr_en), .sum_wr_index(sum_wr_index), .sum_wr_data(sum_wr_data),
        .ring_buffer_pointer(16'h1234), .temperature_reading(16'hbeef), .thr_use_index(thr_use_index),
        .thr_use_data(thr_use_data), .set_use_index(set_use_index), .set_use_data(set_use_data),
        .mapping_control(mapping_control), .card_control_word(card_control_word),
        .sum_write_page(sum_write_page), .init_done(init_done));
    dcm_ctl_model dcm_ctl_model_inst (.clk(clk), .cb_addr(cb_addr), .cb_data_in(cb_data_in), .cb_wr(cb_wr),
        .cb_rd(cb_rd), .cb_data_out(cb_data_out), .cb_data_oe(cb_data_oe));
    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic w(input logic [12:0] a, input logic [7:0] d);
        dcm_ctl_model_inst.bus_write(a, d);
    endtask : w
    task automatic rd_chk(input string n, input logic [12:0] a, input logic [7:0] e);
        logic [7:0] d;
        dcm_ctl_model_inst.bus_read(a, d);
        chk(n, {8'h00, d}, {8'h00, e});
    endtask : rd_chk
    task automatic latch(input logic [2:0] m);
        sum_latch = m;
        tick();
        sum_latch = 3'h0;
        tick();
    endtask : latch
    task automatic sum_wr(input logic [6:0] i, input logic [7:0] d);
        sum_wr_en = 1'b1;
        sum_wr_index = i;
        sum_wr_data = d;
        tick();
        sum_wr_en = 1'b0;
        // Let one edge pass so a following call never re-raises the enable in the same time step.
        tick();
    endtask : sum_wr
    task automatic final_report;
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // Power-on defaults and switch to the native layout.
    task automatic test_reset;
        chk("map reg", {8'h00, mapping_control}, 16'h0000);
        rd_chk("orig imm len", 13'h05ec, 8'h01);
        w(13'h05ff, 8'h80);
        chk("map reg", {8'h00, mapping_control}, 16'h0080);
        rd_chk("len lo", 13'h0540, 8'h01);
        rd_chk("len hi", 13'h0541, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd_chk("page reg", 13'h05e0 + 13'(i), 8'h00);
        end
    endtask : test_reset
    // Threshold bus page and use page are independent.
    task automatic test_thresholds;
        w(13'h05e1, 8'h03);
        for (int i = 0; i < 4; i++) begin
            w(13'h0504 + 13'(i), 8'(8'h11 * (i + 1)));
        end
        w(13'h05e1, 8'h04);
        w(13'h0504, 8'h55);
        w(13'h05e0, 8'h03);
        for (int i = 0; i < 4; i++) begin
            thr_use_index = 6'(4 + i);
            tick();
            chk("thr use", {8'h00, thr_use_data}, {8'h00, 8'(8'h11 * (i + 1))});
        end
        rd_chk("thr bus page", 13'h0504, 8'h55);
    endtask : test_thresholds
    // Settings pages and the preset length on use page 2.
    task automatic test_settings;
        w(13'h05e3, 8'h02);
        w(13'h0568, 8'ha5);
        w(13'h05e2, 8'h02);
        set_use_index = 6'h28;
        tick();
        chk("set use mode", {8'h00, set_use_data}, 16'h00a5);
        set_use_index = 6'h00;
        tick();
        chk("set use len", {8'h00, set_use_data}, 16'h0001);
    endtask : test_settings
    // Sum pages, latch rotation, freeze and read-only sums.
    task automatic test_sums;
        w(13'h05e4, 8'h03);
        sum_wr(7'h10, 8'h9a);
        sum_wr(7'h00, 8'hd1);
        sum_wr(7'h40, 8'hc1);
        sum_wr(7'h60, 8'he9);
        latch(3'b111);
        chk("write page", {13'h0000, sum_write_page}, 16'h0004);
        for (int i = 5; i < 8; i++) begin
            rd_chk("read page", 13'h05e0 + 13'(i), 8'h03);
        end
        rd_chk("fast sum", 13'h0590, 8'h9a);
        rd_chk("smooth sum", 13'h0580, 8'hd1);
        rd_chk("integ", 13'h05c0, 8'hc1);
        w(13'h0580, 8'h00);
        rd_chk("ro sum", 13'h0580, 8'hd1);
        w(13'h05ff, 8'h90);
        rd_chk("waveform", 13'h05c0, 8'he9);
        w(13'h05ff, 8'h80);
        w(13'h05e5, 8'h83);
        latch(3'b001);
        rd_chk("frozen page", 13'h05e5, 8'h83);
        latch(3'b010);
        rd_chk("slow page", 13'h05e6, 8'h05);
        w(13'h05e4, 8'h07);
        latch(3'b100);
        chk("write wrap", {13'h0000, sum_write_page}, 16'h0000);
        rd_chk("vslow page", 13'h05e7, 8'h07);
    endtask : test_sums
    // Broadcast writes land; other cards are not selected.
    task automatic test_broadcast;
        w(13'h13e1, 8'h09);
        rd_chk("bcast", 13'h05e1, 8'h09);
        w(13'h06e1, 8'h0a);
        rd_chk("other card", 13'h05e1, 8'h09);
        rd_chk("ring", 13'h05f6, 8'h34);
        w(13'h05fc, 8'h00);
        rd_chk("temp ro", 13'h05fc, 8'hef);
        w(13'h05f8, 8'h5a);
        w(13'h05f9, 8'hc3);
        chk("ctrl word", card_control_word, 16'hc35a);
        rd_chk("ctrl hi", 13'h05f9, 8'hc3);
    endtask : test_broadcast
    // Original layout goes through the translation table.
    task automatic test_original;
        w(13'h05ff, 8'h00);
        rd_chk("orig smooth32", 13'h05c0, 8'hd1);
        rd_chk("orig smooth16", 13'h0520, 8'hd1);
        rd_chk("orig fast sum", 13'h0510, 8'h9a);
        w(13'h05d0, 8'h3c);
        w(13'h0500, 8'h77);
        w(13'h05ff, 8'h80);
        rd_chk("native gate", 13'h0550, 8'h3c);
        rd_chk("orig thr fast", 13'h0510, 8'h77);
    endtask : test_original
    // Main sequence.
    initial begin
        rst_b = 1'b0;
        sum_latch = 3'h0;
        sum_wr_en = 1'b0;
        sum_wr_index = 7'h00;
        sum_wr_data = 8'h00;
        thr_use_index = 6'h00;
        set_use_index = 6'h00;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int i = 0; i < 40 && init_done !== 1'b1; i++) begin
            tick();
        end
        repeat (4) tick();
        test_reset();
        test_thresholds();
        test_settings();
        test_sums();
        test_broadcast();
        test_original();
        final_report();
    end
    // Watchdog well beyond the expected run of about 700 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule : tb_top
